// ### src/osrc_regs.svh
`ifndef OSRC_REGS_SVH
`define OSRC_REGS_SVH

// ---------------------------------------------------------------
// parameter record layout (record number one, four bytes)
// ---------------------------------------------------------------
`define OSRC_RECORD_NUM        8'h01
`define OSRC_OFS_STOP_REACTION 2'h0
`define OSRC_OFS_SUBST_PATTERN 2'h1
`define OSRC_OFS_UNUSED_TWO    2'h2
`define OSRC_OFS_UNUSED_THREE  2'h3
`define OSRC_BIT_HOLD_LAST     0
`define OSRC_BIT_SUBSTITUTE    1
`define OSRC_STOP_SUPPORTED    8'h03
`define OSRC_RESET_BYTE        8'h00
`define OSRC_ALL_OFF           8'h00
`define OSRC_FAULT_AT_RESET    1'b1

`endif

// ### src/osrc_pkg.sv
package osrc_pkg;
    typedef logic [7:0] osrc_byte_t;

    typedef enum logic [1:0] {
        OSRC_OUT_OFF   = 2'h0,
        OSRC_OUT_HOLD  = 2'h1,
        OSRC_OUT_SUBST = 2'h2
    } osrc_stop_mode_e;
endpackage : osrc_pkg

// ### src/osrc_output_stop_ctrl.sv
`timescale 1ns/100ps
`include "osrc_regs.svh"

module osrc_output_stop_ctrl (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       cpu_run_i,
    input  wire logic [7:0] out_image_i,
    input  wire logic       out_image_wr_i,
    input  wire logic       rec_wr_i,
    input  wire logic [7:0] rec_num_i,
    input  wire logic [1:0] rec_ofs_i,
    input  wire logic [7:0] rec_data_i,
    output logic      [7:0] channel_out_o,
    output logic      [7:0] channel_led_o,
    output logic            group_fault_indicator_o,
    output logic            param_error_o
);

    // ---------------------------------------------------------------
    // run input synchroniser
    // ---------------------------------------------------------------
    logic       run_meta_ff;
    logic       run_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            run_meta_ff <= 1'b0;
            run_ff      <= 1'b0;
        end else begin
            run_meta_ff <= cpu_run_i;
            run_ff      <= run_meta_ff;
        end
    end

    // ---------------------------------------------------------------
    // parameter record
    // ---------------------------------------------------------------
    osrc_pkg::osrc_byte_t stop_reaction_select_ff;
    osrc_pkg::osrc_byte_t substitute_pattern_ff;
    osrc_pkg::osrc_byte_t nxt_stop_reaction_select;
    osrc_pkg::osrc_byte_t nxt_substitute_pattern;
    logic                 params_valid_ff;
    logic                 nxt_params_valid;
    logic                 param_error_ff;
    logic                 nxt_param_error;
    logic                 rec_ok;

    // only record one is ours; others count as wrong parameters
    assign rec_ok = (rec_num_i == `OSRC_RECORD_NUM);

    always_comb begin
        nxt_stop_reaction_select = stop_reaction_select_ff;
        nxt_substitute_pattern   = substitute_pattern_ff;
        nxt_params_valid         = params_valid_ff;
        nxt_param_error          = param_error_ff;
        if (rec_wr_i) begin
            if (!rec_ok) begin
                nxt_param_error = 1'b1;
            end else if (rec_ofs_i == `OSRC_OFS_STOP_REACTION) begin
                if ((rec_data_i & ~`OSRC_STOP_SUPPORTED) != `OSRC_RESET_BYTE) begin
                    nxt_param_error = 1'b1;
                end else begin
                    nxt_stop_reaction_select = rec_data_i;
                    nxt_params_valid         = 1'b1;
                    nxt_param_error          = 1'b0;
                end
            end else if (rec_ofs_i == `OSRC_OFS_SUBST_PATTERN) begin
                nxt_substitute_pattern = rec_data_i;
            end else if (rec_data_i != `OSRC_RESET_BYTE) begin
                // bytes two and three carry nothing; anything nonzero is unsupported
                nxt_param_error = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stop_reaction_select_ff <= `OSRC_RESET_BYTE;
            substitute_pattern_ff   <= `OSRC_RESET_BYTE;
            params_valid_ff         <= 1'b0;
            param_error_ff          <= 1'b0;
        end else begin
            stop_reaction_select_ff <= nxt_stop_reaction_select;
            substitute_pattern_ff   <= nxt_substitute_pattern;
            params_valid_ff         <= nxt_params_valid;
            param_error_ff          <= nxt_param_error;
        end
    end

    // ---------------------------------------------------------------
    // output selection
    // ---------------------------------------------------------------
    osrc_pkg::osrc_byte_t     image_ff;
    osrc_pkg::osrc_byte_t     nxt_image;
    osrc_pkg::osrc_byte_t     out_ff;
    osrc_pkg::osrc_byte_t     nxt_out;
    osrc_pkg::osrc_stop_mode_e stop_mode;

    // both bits set breaks the one-option convention; hold wins
    always_comb begin
        if (stop_reaction_select_ff[`OSRC_BIT_HOLD_LAST]) begin
            stop_mode = osrc_pkg::OSRC_OUT_HOLD;
        end else if (stop_reaction_select_ff[`OSRC_BIT_SUBSTITUTE]) begin
            stop_mode = osrc_pkg::OSRC_OUT_SUBST;
        end else begin
            stop_mode = osrc_pkg::OSRC_OUT_OFF;
        end
    end

    always_comb begin
        nxt_image = image_ff;
        if (out_image_wr_i && run_ff) begin
            nxt_image = out_image_i;
        end
        nxt_out = `OSRC_ALL_OFF;
        if (run_ff && params_valid_ff) begin
            nxt_out = nxt_image;
        end else if (params_valid_ff) begin
            case (stop_mode)
                osrc_pkg::OSRC_OUT_HOLD:  nxt_out = out_ff;
                osrc_pkg::OSRC_OUT_SUBST: nxt_out = substitute_pattern_ff;
                default:                  nxt_out = `OSRC_ALL_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            image_ff <= `OSRC_ALL_OFF;
            out_ff   <= `OSRC_ALL_OFF;
        end else begin
            image_ff <= nxt_image;
            out_ff   <= nxt_out;
        end
    end

    // ---------------------------------------------------------------
    // indicators; channel lamps load the same next value as the outputs
    // ---------------------------------------------------------------
    osrc_pkg::osrc_byte_t led_ff;
    osrc_pkg::osrc_byte_t nxt_led;
    logic                 fault_ff;
    logic                 nxt_fault;

    always_comb begin
        nxt_led   = nxt_out;
        nxt_fault = !nxt_params_valid || nxt_param_error;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            led_ff   <= `OSRC_ALL_OFF;
            fault_ff <= `OSRC_FAULT_AT_RESET;
        end else begin
            led_ff   <= nxt_led;
            fault_ff <= nxt_fault;
        end
    end

    assign channel_out_o           = out_ff;
    assign channel_led_o           = led_ff;
    assign group_fault_indicator_o = fault_ff;
    assign param_error_o           = param_error_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_fault_unparam: assert property (@(posedge clk_i) disable iff (reset_i)
        !params_valid_ff |-> group_fault_indicator_o)
        else $error("fault lamp off without parameters");

    chk_led_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        channel_led_o == channel_out_o)
        else $error("channel lamp differs from output");

    chk_bad_rejected: assert property (@(posedge clk_i) disable iff (reset_i)
        rec_wr_i && !rec_ok |=> param_error_o && $stable(stop_reaction_select_ff))
        else $error("wrong record applied or not flagged");

    chk_hold_freeze: assert property (@(posedge clk_i) disable iff (reset_i)
        !run_ff && params_valid_ff && stop_reaction_select_ff[`OSRC_BIT_HOLD_LAST]
        && !$past(run_ff) |=> $stable(channel_out_o))
        else $error("held outputs changed at stop");

    chk_subst_drive: assert property (@(posedge clk_i) disable iff (reset_i)
        !run_ff && params_valid_ff && stop_reaction_select_ff[`OSRC_BIT_SUBSTITUTE]
        && !stop_reaction_select_ff[`OSRC_BIT_HOLD_LAST]
        |=> channel_out_o == $past(substitute_pattern_ff))
        else $error("substitute pattern not driven");

    chk_run_image: assert property (@(posedge clk_i) disable iff (reset_i)
        run_ff && params_valid_ff && out_image_wr_i |=> channel_out_o == $past(out_image_i))
        else $error("output image not applied");

    chk_none_off: assert property (@(posedge clk_i) disable iff (reset_i)
        !run_ff && params_valid_ff && stop_reaction_select_ff == `OSRC_RESET_BYTE
        |=> channel_out_o == `OSRC_ALL_OFF)
        else $error("outputs not off at stop");

    chk_rewrite_apply: assert property (@(posedge clk_i) disable iff (reset_i)
        rec_wr_i && rec_ok && rec_ofs_i == `OSRC_OFS_SUBST_PATTERN
        |=> substitute_pattern_ff == $past(rec_data_i))
        else $error("pattern rewrite not taken");

    chk_fault_error: assert property (@(posedge clk_i) disable iff (reset_i)
        param_error_o |-> group_fault_indicator_o)
        else $error("fault lamp off with wrong parameter");

    chk_mode_store: assert property (@(posedge clk_i) disable iff (reset_i)
        rec_wr_i && rec_ok && rec_ofs_i == `OSRC_OFS_STOP_REACTION
        && (rec_data_i & ~`OSRC_STOP_SUPPORTED) == `OSRC_RESET_BYTE
        |=> stop_reaction_select_ff == $past(rec_data_i) && !param_error_o)
        else $error("stop reaction byte not taken");

endmodule : osrc_output_stop_ctrl

// ### verification/osrc_cpu_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// controlling cpu: drives on the falling edge, one byte a write
// ---------------------------------------------------------------
module osrc_cpu_model (
    input  wire logic       clk_i,
    output logic            run_o,
    output logic      [7:0] image_o,
    output logic            image_wr_o,
    output logic            rec_wr_o,
    output logic      [7:0] rec_num_o,
    output logic      [1:0] rec_ofs_o,
    output logic      [7:0] rec_data_o
);
    initial begin
        run_o      = 1'b0;
        image_o    = 8'h00;
        image_wr_o = 1'b0;
        rec_wr_o   = 1'b0;
        rec_num_o  = 8'h00;
        rec_ofs_o  = 2'h0;
        rec_data_o = 8'h00;
    end

    task automatic run(input logic r);
        @(negedge clk_i);
        run_o = r;
    endtask : run

    // the record always travels as record one unless a refusal is wanted
    task automatic rec(input logic [7:0] num, input logic [1:0] ofs, input logic [7:0] d);
        @(negedge clk_i);
        rec_num_o  = num;
        rec_ofs_o  = ofs;
        rec_data_o = d;
        rec_wr_o   = 1'b1;
        @(negedge clk_i);
        rec_wr_o   = 1'b0;
        // released data is inverted so a stale value cannot pass
        rec_data_o = ~d;
    endtask : rec

    task automatic img(input logic [7:0] v);
        @(negedge clk_i);
        image_o    = v;
        image_wr_o = 1'b1;
        @(negedge clk_i);
        image_wr_o = 1'b0;
        image_o    = ~v;
    endtask : img
endmodule : osrc_cpu_model

// ### verification/tb_output_stop_reaction_control.sv
`timescale 1ns/100ps
module tb_output_stop_reaction_control;
    logic       clk_i      = 1'b0;
    logic       reset_i    = 1'b1;
    logic       run;
    logic       img_wr;
    logic       rec_wr;
    logic       fault;
    logic       perr;
    logic [7:0] img;
    logic [7:0] rec_num;
    logic [7:0] rec_data;
    logic [7:0] ch_out;
    logic [7:0] ch_led;
    logic [7:0] v;
    logic [7:0] p;
    logic [1:0] rec_ofs;
    int         n_mismatch = 0;
    int         compares   = 0;
    int         seed       = 39285;

    always #12.5 clk_i = ~clk_i;

    osrc_cpu_model cpu (.clk_i(clk_i), .run_o(run), .image_o(img), .image_wr_o(img_wr),
        .rec_wr_o(rec_wr), .rec_num_o(rec_num), .rec_ofs_o(rec_ofs), .rec_data_o(rec_data));

    osrc_output_stop_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .cpu_run_i(run),
        .out_image_i(img), .out_image_wr_i(img_wr), .rec_wr_i(rec_wr), .rec_num_i(rec_num),
        .rec_ofs_i(rec_ofs), .rec_data_i(rec_data), .channel_out_o(ch_out),
        .channel_led_o(ch_led), .group_fault_indicator_o(fault), .param_error_o(perr));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wait_cyc

    // both bits set: hold wins, neither: all off
    function automatic logic [7:0] stop_val(input logic [7:0] m, input logic [7:0] last,
                                            input logic [7:0] pat);
        if (m[0])
            return last;
        if (m[1])
            return pat;
        return 8'h00;
    endfunction : stop_val

    task automatic stop_test;
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        wait_cyc(1);
        chk("fault", {7'h00, fault}, 8'h01);
        chk("out", ch_out, 8'h00);
        // pattern before mode byte: still unparameterised, outputs stay off
        cpu.run(1'b1);
        cpu.rec(8'h01, 2'h1, 8'hFF);
        cpu.img(8'hFF);
        wait_cyc(3);
        chk("early fault", {7'h00, fault}, 8'h01);
        chk("early out", ch_out, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            p = 8'($random(seed));
            cpu.run(1'b1);
            // i == 3 breaks the one-option convention on purpose to check hold wins
            cpu.rec(8'h01, 2'h0, 8'(i));
            cpu.rec(8'h01, 2'h1, p);
            cpu.img(v);
            wait_cyc(3);
            chk("fault", {7'h00, fault}, 8'h00);
            chk("out", ch_out, v);
            chk("led", ch_led, v);
            cpu.run(1'b0);
            wait_cyc(4);
            cpu.img(~v);
            wait_cyc(3);
            chk("stop out", ch_out, stop_val(8'(i), v, p));
            chk("stop led", ch_led, stop_val(8'(i), v, p));
        end
        for (int k = 0; k < 4; k++) begin
            cpu.rec(k == 0 ? 8'h02 : 8'h01, k >= 2 ? 2'(k) : 2'h0, k == 1 ? 8'h40 : 8'h5A);
            wait_cyc(1);
            chk("error", {7'h00, perr}, 8'h01);
            chk("fault", {7'h00, fault}, 8'h01);
            cpu.rec(8'h01, 2'h0, 8'h01);
            wait_cyc(1);
            chk("error", {7'h00, perr}, 8'h00);
        end
        cpu.rec(8'h01, 2'h2, 8'h00);
        wait_cyc(1);
        chk("zero spare", {7'h00, perr}, 8'h00);
        reset_i = 1'b1;
        wait_cyc(2);
        reset_i = 1'b0;
        wait_cyc(1);
        chk("reset fault", {7'h00, fault}, 8'h01);
        chk("reset out", ch_out, 8'h00);
        chk("reset error", {7'h00, perr}, 8'h00);
        stop_test();
    end

    initial begin
        repeat (2000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule : tb_output_stop_reaction_control
